// ---- hdl/ebr_top.sv ----
// How it works
// - Array holds 4608 bits including parity
// - Aspect ratios from 4Kx1 up to 128x36
// - Deepest organisation is 4K words by 1
// - Wide 128-word shapes refused in true dual-port
// - Ninth bit per byte stored, never checked
// - Byte writes at write widths of 16 bits and up; narrower widths use be[0] as the word enable
// - Disabled bytes keep their previous contents
// - Packing splits block into two half singles
// - Address hold freezes the address register
// - Contents preloadable through the init registers
// - Data outputs read zero after reset
// - Clear touches output registers only
// - Same-port read during write returns new data
// - Other-port read during write returns old data
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "ebr_consts.svh"

module ebr_port #(
	parameter int AW  = `EBR_AW,
	parameter int DW  = `EBR_DW,
	parameter int BW  = `EBR_BW,
	parameter int BAW = `EBR_BAW,
	parameter int NB  = `EBR_NB
) (
	input  wire logic               clk,    // Clock
	input  wire logic               rst_n,  // Async reset, low
	input  wire logic [AW-1:0]      addr,   // Word address
	input  wire logic [DW-1:0]      wdata,  // Write data
	input  wire logic               we,     // Write enable
	input  wire logic [NB-1:0]      be,     // Byte enables
	input  wire logic               ahold,  // Address hold, high freezes
	input  wire logic               oclr,   // Output register clear
	input  wire ebr_pkg::ebr_wid_t  wid,    // Port width
	input  wire logic               wr_ok,  // Mode allows writes
	input  wire logic               rd_ok,  // Mode allows reads
	input  wire logic               pack_en, // Packed mode
	input  wire logic               hi,     // Half used when packed
	input  wire logic [NB*BW-1:0]   old,    // Array bytes at base
	output logic      [BAW-1:0]     base,   // First byte address
	output logic      [NB*BW-1:0]   wb,     // Bytes to store
	output logic      [NB-1:0]      wen,    // Byte write strobes
	output logic      [DW-1:0]      dout    // Read data
);
	logic [AW-1:0] addr_r;
	logic [DW-1:0] wd_r;
	logic          we_r;
	logic [NB-1:0] be_r;
	logic [DW-1:0] dout_r;
	logic [DW-1:0] dout_nxt;
	logic [DW-1:0] rv;
	logic [BW-1:0] o;
	logic [BW-1:0] nw;

	wire logic sub = (wid == ebr_pkg::EBR_W1) || (wid == ebr_pkg::EBR_W2)
		|| (wid == ebr_pkg::EBR_W4);
	wire logic par = (wid == ebr_pkg::EBR_W9) || (wid == ebr_pkg::EBR_W18)
		|| (wid == ebr_pkg::EBR_W36);
	wire logic [1:0] lw = (wid == ebr_pkg::EBR_W2) ? 2'h1 :
		(wid == ebr_pkg::EBR_W4) ? 2'h2 : 2'h0;
	wire logic [1:0] nbl = ((wid == ebr_pkg::EBR_W16) ||
		(wid == ebr_pkg::EBR_W18)) ? 2'h1 :
		((wid == ebr_pkg::EBR_W32) || (wid == ebr_pkg::EBR_W36)) ? 2'h2 :
		2'h0;
	// Sub-byte words share a byte; wider words span 2^nbl bytes
	wire logic [AW-1:0] idx = sub ? (addr_r >> (2'h3 - lw))
		: (addr_r << nbl);
	wire logic [2:0] boff = sub ? 3'(addr_r[2:0] << lw) : 3'h0;
	wire logic [3:0] wbits = 4'h1 << lw;
	wire logic [7:0] wmask = 8'((9'h001 << wbits) - 9'h001);

	// Packed halves are pinned by the top address bit
	assign base = pack_en ? {hi, idx[BAW-2:0]} : idx[BAW-1:0];
	assign dout = dout_r;

	always_comb begin
		wb = old;
		wen = '0;
		rv = '0;
		o = '0;
		nw = '0;
		for (int j = 0; j < NB; j++) begin
			o = old[BW*j +: BW];
			if (sub)
				nw = {o[8], (o[7:0] & ~(wmask << boff)) |
					((wd_r[7:0] & wmask) << boff)};
			else if (par)
				nw = wd_r[BW*j +: BW];
			else
				nw = {o[8], wd_r[8*j +: 8]};
			wen[j] = we_r && wr_ok && ((3'(j) >> nbl) == 3'h0) &&
				(sub ? be_r[0] : be_r[j]);
			wb[BW*j +: BW] = wen[j] ? nw : o;
		end
		// Read view taken from merged bytes gives new data here
		if (sub)
			rv = DW'((wb[7:0] >> boff) & wmask);
		else
			for (int j = 0; j < NB; j++) begin
				if ((3'(j) >> nbl) == 3'h0) begin
					if (par)
						rv[BW*j +: BW] = wb[BW*j +: BW];
					else
						rv[8*j +: 8] = wb[BW*j +: 8];
				end
			end
	end

	assign dout_nxt = oclr ? '0 : (rd_ok ? rv : dout_r);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_r <= '0;
			wd_r   <= '0;
			we_r   <= 1'b0;
			be_r   <= '0;
			dout_r <= '0;
		end else begin
			if (!ahold)
				addr_r <= addr;
			wd_r   <= wdata;
			we_r   <= we;
			be_r   <= be;
			dout_r <= dout_nxt;
		end
	end
endmodule

module ebr_top #(
	parameter int AW  = `EBR_AW,
	parameter int DW  = `EBR_DW,
	parameter int NB  = `EBR_NB
) (
	input  wire logic                pclk,      // Clock, 25 MHz
	input  wire logic                presetn,   // Async reset, low
	input  wire logic                psel,      // APB select
	input  wire logic                penable,   // APB enable
	input  wire logic                pwrite,    // APB direction
	input  wire logic [`EBR_PAW-1:0] paddr,     // APB address
	input  wire logic [31:0]         pwdata,    // APB write data
	output logic      [31:0]         prdata,    // APB read data
	output logic                     pready,    // APB ready
	output logic                     pslverr,   // APB error
	input  wire logic [AW-1:0]       a_addr,    // Port A address
	input  wire logic [DW-1:0]       a_wdata,   // Port A write data
	input  wire logic                a_we,      // Port A write enable
	input  wire logic [NB-1:0]       a_be,      // Port A byte enables
	input  wire logic                a_ahold,   // Port A address hold
	input  wire logic                a_oclr,    // Port A output clear
	output logic      [DW-1:0]       a_rdata,   // Port A read data
	input  wire logic [AW-1:0]       b_addr,    // Port B address
	input  wire logic [DW-1:0]       b_wdata,   // Port B write data
	input  wire logic                b_we,      // Port B write enable
	input  wire logic [NB-1:0]       b_be,      // Port B byte enables
	input  wire logic                b_ahold,   // Port B address hold
	input  wire logic                b_oclr,    // Port B output clear
	output logic      [DW-1:0]       b_rdata    // Port B read data
);
	localparam int BW  = `EBR_BW;
	localparam int BAW = `EBR_BAW;

	logic [BW-1:0]           mem [0:`EBR_BYTES-1];
	logic [`EBR_CFG_W-1:0]   cfg_r;
	logic                    err_r;
	logic                    err_nxt;
	logic [BAW-1:0]          iaddr_r;
	logic [31:0]             prdata_r;
	logic [BAW-1:0]          a_base;
	logic [BAW-1:0]          b_base;
	logic [NB*BW-1:0]        a_old;
	logic [NB*BW-1:0]        b_old;
	logic [NB*BW-1:0]        a_wb;
	logic [NB*BW-1:0]        b_wb;
	logic [NB-1:0]           a_wen;
	logic [NB-1:0]           b_wen;

	wire ebr_pkg::ebr_mode_t mode =
		ebr_pkg::ebr_mode_t'(cfg_r[`EBR_CFG_MODE]);
	wire ebr_pkg::ebr_wid_t wid_a = ebr_pkg::ebr_wid_t'(cfg_r[`EBR_CFG_WA]);
	wire ebr_pkg::ebr_wid_t wid_b = ebr_pkg::ebr_wid_t'(cfg_r[`EBR_CFG_WB]);
	wire logic pk = cfg_r[`EBR_CFG_PACK];

	// Port roles per operating mode
	wire logic a_wr_ok = (mode != ebr_pkg::EBR_ROM);
	wire logic a_rd_ok = (mode != ebr_pkg::EBR_SDP);
	wire logic b_wr_ok = (mode == ebr_pkg::EBR_TDP) ||
		((mode == ebr_pkg::EBR_SP) && pk);
	wire logic b_rd_ok = (mode != ebr_pkg::EBR_SP) || pk;

	// APB decode
	wire logic setup    = psel && !penable;
	wire logic access   = psel && penable;
	wire logic hit_cfg  = (paddr == `EBR_OFS_CFG);
	wire logic hit_stat = (paddr == `EBR_OFS_STAT);
	wire logic hit_ia   = (paddr == `EBR_OFS_IADDR);
	wire logic hit_id   = (paddr == `EBR_OFS_IDATA);
	wire logic mapped   = hit_cfg || hit_stat || hit_ia || hit_id;
	wire logic wr       = access && pwrite && mapped;
	wire logic init_wr  = wr && hit_id;

	// Configuration check on a write
	wire logic [3:0] nwa  = pwdata[`EBR_CFG_WA];
	wire logic [3:0] nwb  = pwdata[`EBR_CFG_WB];
	wire logic [1:0] nmd  = pwdata[`EBR_CFG_MODE];
	wire logic       npk  = pwdata[`EBR_CFG_PACK];
	wire logic wide_a = (nwa == ebr_pkg::EBR_W32) || (nwa == ebr_pkg::EBR_W36);
	wire logic wide_b = (nwb == ebr_pkg::EBR_W32) || (nwb == ebr_pkg::EBR_W36);
	wire logic cfg_ok = (nwa <= ebr_pkg::EBR_W36) &&
		(nwb <= ebr_pkg::EBR_W36) &&
		!((nmd == ebr_pkg::EBR_TDP) && (wide_a || wide_b)) &&
		!(npk && (nmd != ebr_pkg::EBR_SP));
	wire logic cfg_bad = wr && hit_cfg && !cfg_ok;

	// Error flag: a new refusal wins over a clear in the same cycle
	assign err_nxt = cfg_bad ||
		(err_r && !(wr && hit_stat && pwdata[`EBR_STAT_ERR]));

	wire logic [31:0] rd_mux =
		hit_cfg  ? 32'(cfg_r) :
		hit_stat ? 32'(err_r) :
		hit_ia   ? 32'(iaddr_r) :
		hit_id   ? 32'(mem[iaddr_r]) : 32'h0000_0000;

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r    <= `EBR_CFG_RST;
			err_r    <= 1'b0;
			iaddr_r  <= '0;
			prdata_r <= '0;
		end else begin
			if (wr && hit_cfg && cfg_ok)
				cfg_r <= pwdata[`EBR_CFG_W-1:0];
			err_r <= err_nxt;
			if (wr && hit_ia)
				iaddr_r <= pwdata[BAW-1:0];
			else if (init_wr)
				iaddr_r <= iaddr_r + 1'b1;
			if (setup && !pwrite)
				prdata_r <= rd_mux;
		end
	end

	// Both ports see the array before this edge's writes
	always_comb begin
		for (int j = 0; j < NB; j++) begin
			a_old[BW*j +: BW] = mem[a_base + BAW'(j)];
			b_old[BW*j +: BW] = mem[b_base + BAW'(j)];
		end
	end

	// Array has no reset; port writes follow the init load
	always_ff @(posedge pclk) begin
		if (init_wr)
			mem[iaddr_r] <= pwdata[BW-1:0];
		for (int j = 0; j < NB; j++) begin
			if (a_wen[j])
				mem[a_base + BAW'(j)] <= a_wb[BW*j +: BW];
			if (b_wen[j])
				mem[b_base + BAW'(j)] <= b_wb[BW*j +: BW];
		end
	end

	ebr_port #(.AW(AW), .DW(DW), .BW(BW), .BAW(BAW), .NB(NB)) u_port_a (
		.clk    (pclk),
		.rst_n  (presetn),
		.addr   (a_addr),
		.wdata  (a_wdata),
		.we     (a_we),
		.be     (a_be),
		.ahold  (a_ahold),
		.oclr   (a_oclr),
		.wid    (wid_a),
		.wr_ok  (a_wr_ok),
		.rd_ok  (a_rd_ok),
		.pack_en(pk),
		.hi     (1'b0),
		.old    (a_old),
		.base   (a_base),
		.wb     (a_wb),
		.wen    (a_wen),
		.dout   (a_rdata)
	);

	ebr_port #(.AW(AW), .DW(DW), .BW(BW), .BAW(BAW), .NB(NB)) u_port_b (
		.clk    (pclk),
		.rst_n  (presetn),
		.addr   (b_addr),
		.wdata  (b_wdata),
		.we     (b_we),
		.be     (b_be),
		.ahold  (b_ahold),
		.oclr   (b_oclr),
		.wid    (wid_b),
		.wr_ok  (b_wr_ok),
		.rd_ok  (b_rd_ok),
		.pack_en(pk),
		.hi     (1'b1),
		.old    (b_old),
		.base   (b_base),
		.wb     (b_wb),
		.wen    (b_wen),
		.dout   (b_rdata)
	);
endmodule

// ---- hdl/ebr_consts.svh ----
`ifndef EBR_CONSTS_SVH
`define EBR_CONSTS_SVH

// Array geometry: 512 bytes of 9 bits, parity bit 8 of each byte
`define EBR_BITS      4608
`define EBR_BYTES     512
`define EBR_BW        9
`define EBR_BAW       9
`define EBR_AW        12
`define EBR_DW        36
`define EBR_NB        4

// Register map, byte addresses
`define EBR_PAW       12
`define EBR_OFS_CFG   12'h000
`define EBR_OFS_STAT  12'h004
`define EBR_OFS_IADDR 12'h008
`define EBR_OFS_IDATA 12'h00C

// Configuration register fields
`define EBR_CFG_W     11
`define EBR_CFG_MODE  1:0
`define EBR_CFG_WA    5:2
`define EBR_CFG_WB    9:6
`define EBR_CFG_PACK  10
`define EBR_CFG_RST   11'h110

// Status register fields
`define EBR_STAT_ERR  0

`endif

// ---- hdl/ebr_pkg.sv ----
package ebr_pkg;

	typedef enum logic [1:0] {
		EBR_SP  = 2'h0,
		EBR_SDP = 2'h1,
		EBR_TDP = 2'h2,
		EBR_ROM = 2'h3
	} ebr_mode_t;

	typedef enum logic [3:0] {
		EBR_W1  = 4'h0,
		EBR_W2  = 4'h1,
		EBR_W4  = 4'h2,
		EBR_W8  = 4'h3,
		EBR_W9  = 4'h4,
		EBR_W16 = 4'h5,
		EBR_W18 = 4'h6,
		EBR_W32 = 4'h7,
		EBR_W36 = 4'h8
	} ebr_wid_t;

endpackage

// ---- verification/ebr_top_sva.sv ----
`timescale 1ns/1ns
`include "ebr_consts.svh"
module ebr_top_chk #(
	parameter int DW = `EBR_DW
) (
	input wire logic                pclk,    // Clock
	input wire logic                presetn, // Reset, low
	input wire logic                psel,    // APB select
	input wire logic                penable, // APB enable
	input wire logic                pwrite,  // APB direction
	input wire logic [`EBR_PAW-1:0] paddr,   // APB address
	input wire logic [31:0]         prdata,  // APB read data
	input wire logic                pready,  // APB ready
	input wire logic                pslverr, // APB error
	input wire logic                a_we,    // A write enable
	input wire logic                b_we,    // B write enable
	input wire logic                a_ahold, // A address hold
	input wire logic                a_oclr,  // A clear
	input wire logic                b_oclr,  // B clear
	input wire logic [DW-1:0]       a_rdata, // A read data
	input wire logic [DW-1:0]       b_rdata  // B read data
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Held address, no writer anywhere, no clear
	sequence quiet_s;
		a_ahold && !a_we && !b_we && !psel && !a_oclr;
	endsequence
	ready_hi_a: assert property (pready)
		else $error("pready low");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	err_map_a: assert property (psel && penable && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > `EBR_OFS_IDATA))
		else $error("address decode wrong");
	prd_hold_a: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata)) else $error("prdata moved");
	out_rst_a: assert property (disable iff (1'b0)
		!presetn |-> a_rdata == '0 && b_rdata == '0 && prdata == 32'h0)
		else $error("outputs not zero in reset");
	a_clr_a: assert property (a_oclr |=> a_rdata == '0)
		else $error("port A output not cleared");
	b_clr_a: assert property (b_oclr |=> b_rdata == '0)
		else $error("port B output not cleared");
	addr_hold_a: assert property (quiet_s [*3] |=> $stable(a_rdata))
		else $error("held address changed read data");
endmodule

bind ebr_top ebr_top_chk #(.DW(DW)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .a_we(a_we), .b_we(b_we), .a_ahold(a_ahold),
	.a_oclr(a_oclr), .b_oclr(b_oclr), .a_rdata(a_rdata), .b_rdata(b_rdata)
);

// ---- verification/ebr_user.sv ----
`timescale 1ns/1ns
`include "ebr_consts.svh"
module ebr_user (
	input  wire logic              clk,     // Clock
	output logic [`EBR_AW-1:0]     a_addr,  // A address
	output logic [`EBR_DW-1:0]     a_wdata, // A write data
	output logic                   a_we,    // A write enable
	output logic [`EBR_NB-1:0]     a_be,    // A byte enables
	output logic                   a_ahold, // A address hold
	output logic                   a_oclr,  // A clear
	output logic [`EBR_AW-1:0]     b_addr,  // B address
	output logic [`EBR_DW-1:0]     b_wdata, // B write data
	output logic                   b_we,    // B write enable
	output logic [`EBR_NB-1:0]     b_be,    // B byte enables
	output logic                   b_ahold, // B address hold
	output logic                   b_oclr   // B clear
);
	initial begin
		{a_addr, a_wdata, a_we, a_be, a_ahold, a_oclr} = '0;
		{b_addr, b_wdata, b_we, b_be, b_ahold, b_oclr} = '0;
	end
	// One access on both ports; returns once read data has settled
	task automatic cyc(input logic [`EBR_AW-1:0] aa, ba,
		input logic [`EBR_DW-1:0] ad, bd, input logic awe, bwe,
		input logic [`EBR_NB-1:0] abe, bbe);
		@(posedge clk);
		a_addr <= aa;
		b_addr <= ba;
		a_wdata <= ad;
		b_wdata <= bd;
		a_we <= awe;
		b_we <= bwe;
		a_be <= abe;
		b_be <= bbe;
		@(posedge clk);
		a_we <= 1'b0;
		b_we <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic ctl(input logic ah, oc);
		@(posedge clk);
		a_ahold <= ah;
		b_ahold <= ah;
		a_oclr <= oc;
		b_oclr <= oc;
	endtask
endmodule

// ---- verification/ebr_top_tb_top.sv ----
`timescale 1ns/1ns
`include "ebr_consts.svh"
module ebr_top_tb_top;
	logic                pclk, presetn, psel, penable, pwrite;
	logic [`EBR_PAW-1:0] paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic                pready, pslverr, err;
	logic [`EBR_AW-1:0]  a_addr, b_addr;
	logic [`EBR_DW-1:0]  a_wdata, b_wdata, a_rdata, b_rdata;
	logic                a_we, b_we, a_ahold, b_ahold, a_oclr, b_oclr;
	logic [`EBR_NB-1:0]  a_be, b_be;
	int                  fail_count, samples_checked;

	ebr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.a_addr(a_addr), .a_wdata(a_wdata), .a_we(a_we), .a_be(a_be),
		.a_ahold(a_ahold), .a_oclr(a_oclr), .a_rdata(a_rdata),
		.b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_be(b_be),
		.b_ahold(b_ahold), .b_oclr(b_oclr), .b_rdata(b_rdata));
	ebr_user u_usr (.clk(pclk), .a_addr(a_addr), .a_wdata(a_wdata),
		.a_we(a_we), .a_be(a_be), .a_ahold(a_ahold), .a_oclr(a_oclr),
		.b_addr(b_addr), .b_wdata(b_wdata), .b_we(b_we), .b_be(b_be),
		.b_ahold(b_ahold), .b_oclr(b_oclr));

	function automatic logic [31:0] cfgv(input logic [1:0] m,
		input logic [3:0] wa, wb);
		return {22'h0, wb, wa, m};
	endfunction
	task automatic chk(input logic [35:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] ad,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_reset;
		chk(a_rdata, 36'h0);
		chk(b_rdata, 36'h0);
		apb(1'b0, `EBR_OFS_CFG, 32'h0);
		chk({4'h0, rd}, 36'h110);
	endtask
	task automatic t_widths;
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, `EBR_OFS_CFG, cfgv(2'h0, 4'(i), 4'(i)));
			apb(1'b0, `EBR_OFS_CFG, 32'h0);
			chk({4'h0, rd}, {4'h0, cfgv(2'h0, 4'(i), 4'(i))});
		end
	endtask
	task automatic t_refuse;
		apb(1'b1, `EBR_OFS_CFG, cfgv(ebr_pkg::EBR_TDP, ebr_pkg::EBR_W36,
			ebr_pkg::EBR_W36));
		apb(1'b0, `EBR_OFS_CFG, 32'h0);
		chk({4'h0, rd}, 36'h220);
		apb(1'b0, `EBR_OFS_STAT, 32'h0);
		chk({4'h0, rd}, 36'h1);
		apb(1'b1, `EBR_OFS_STAT, 32'h1);
		apb(1'b0, `EBR_OFS_STAT, 32'h0);
		chk({4'h0, rd}, 36'h0);
	endtask
	// True dual-port at 18 bits: byte masks and read-during-write
	task automatic t_tdp;
		apb(1'b1, `EBR_OFS_CFG, cfgv(ebr_pkg::EBR_TDP, ebr_pkg::EBR_W18,
			ebr_pkg::EBR_W18));
		u_usr.cyc(0, 0, 36'hFFFFFFFFF, 0, 1, 0, 4'h3, 0);
		u_usr.cyc(0, 0, 36'h0, 0, 1, 0, 4'h1, 0);
		chk(a_rdata, 36'h3FE00);
		u_usr.cyc(1, 0, 36'h2AAAA, 0, 1, 0, 4'h3, 0);
		u_usr.cyc(1, 1, 36'h15555, 0, 1, 0, 4'h3, 0);
		chk(b_rdata, 36'h2AAAA);
		chk(a_rdata, 36'h15555);
		u_usr.cyc(2, 2, 0, 36'h0ABCD, 0, 1, 0, 4'h3);
		chk(b_rdata, 36'h0ABCD);
		u_usr.cyc(2, 0, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h0ABCD);
	endtask
	task automatic t_hold;
		u_usr.ctl(1, 0);
		u_usr.cyc(1, 1, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h0ABCD);
		u_usr.ctl(1, 1);
		u_usr.ctl(1, 0);
		#1;
		chk(a_rdata, 36'h0);
		chk(b_rdata, 36'h0);
		u_usr.ctl(0, 0);
		u_usr.cyc(2, 0, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h0ABCD);
	endtask
	task automatic t_init;
		apb(1'b1, `EBR_OFS_CFG, 32'h110);
		apb(1'b1, `EBR_OFS_IADDR, 32'h10);
		apb(1'b1, `EBR_OFS_IDATA, 32'h155);
		apb(1'b1, `EBR_OFS_IDATA, 32'h0AA);
		u_usr.cyc(12'h010, 0, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h155);
		u_usr.cyc(12'h011, 0, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h0AA);
		apb(1'b0, 12'h040, 32'h0);
		chk({35'h0, err}, 36'h1);
		chk({4'h0, rd}, 36'h0);
	endtask
	// ROM refuses writes; one-bit words; packed halves stay apart
	task automatic t_modes;
		apb(1'b1, `EBR_OFS_CFG, cfgv(ebr_pkg::EBR_ROM, ebr_pkg::EBR_W9,
			ebr_pkg::EBR_W9));
		u_usr.cyc(12'h010, 12'h011, 0, 0, 1, 1, 4'h1, 4'h1);
		chk(a_rdata, 36'h155);
		chk(b_rdata, 36'h0AA);
		apb(1'b1, `EBR_OFS_CFG, cfgv(ebr_pkg::EBR_SP, ebr_pkg::EBR_W1,
			ebr_pkg::EBR_W1));
		u_usr.cyc(12'h011, 0, 36'h1, 0, 1, 0, 4'h1, 0);
		chk(a_rdata, 36'h1);
		u_usr.cyc(12'h012, 0, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h1);
		u_usr.cyc(12'h013, 0, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h0);
		apb(1'b1, `EBR_OFS_CFG, cfgv(ebr_pkg::EBR_SP, ebr_pkg::EBR_W8,
			ebr_pkg::EBR_W8) | (32'h1 << `EBR_CFG_PACK));
		u_usr.cyc(12'h003, 12'h003, 36'h5A, 36'hA5, 1, 1, 4'h1, 4'h1);
		u_usr.cyc(12'h003, 12'h003, 0, 0, 0, 0, 0, 0);
		chk(a_rdata, 36'h05A);
		chk(b_rdata, 36'h0A5);
		apb(1'b1, `EBR_OFS_CFG, cfgv(ebr_pkg::EBR_TDP, ebr_pkg::EBR_W1,
			ebr_pkg::EBR_W1) | (32'h1 << `EBR_CFG_PACK));
		apb(1'b0, `EBR_OFS_STAT, 32'h0);
		chk({4'h0, rd}, 36'h1);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		#200000;
		fail_count++;
		test_done;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		fail_count = 0;
		samples_checked = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_widths;
		t_refuse;
		t_tdp;
		t_hold;
		t_init;
		t_modes;
		test_done;
	end
endmodule
